// >>> common/atsm_pkg.sv
// Constants, types and register layout for the transmit slot mapper.
// Assumes a single clock domain; the link pins are synchronised onto clk inside atsm_top.
package atsm_pkg;
   // Register offsets on the control port
   localparam logic [7:0] ATSM_OFF_PIN_SEL = 8'h1d;
   localparam logic [7:0] ATSM_OFF_CH1     = 8'h1e;
   localparam logic [7:0] ATSM_OFF_CH2     = 8'h1f;
   localparam logic [7:0] ATSM_OFF_CH3     = 8'h20;
   // Reset values
   localparam logic [7:0] ATSM_RST_PIN_SEL = 8'h00;
   localparam logic [7:0] ATSM_RST_CH1     = 8'h20;
   localparam logic [7:0] ATSM_RST_CH2     = 8'h21;
   localparam logic [7:0] ATSM_RST_CH3     = 8'h02;
   // Field positions
   localparam int ATSM_SLOT_LSB = 0;
   localparam int ATSM_SLOT_MSB = 4;
   localparam int ATSM_EN_BIT   = 5;
   localparam int ATSM_SRC_LSB  = 5;
   localparam int ATSM_SRC_MSB  = 6;
   // Writable bits per register; the rest read as zero
   localparam logic [7:0] ATSM_MASK_CH12    = 8'h3f;
   localparam logic [7:0] ATSM_MASK_CH3     = 8'h7f;
   localparam logic [7:0] ATSM_MASK_PIN_SEL = 8'h07;
   // Frame geometry
   localparam int         ATSM_WORD_W    = 32;
   localparam int         ATSM_CHANNELS  = 3;
   localparam logic [4:0] ATSM_TDM_LAST  = 5'h1f;
   localparam logic [4:0] ATSM_HALF_LAST = 5'h0f;

   // Channel three source codes
   typedef enum logic [1:0] {
      ATSM_SRC_HIZ  = 2'h0,
      ATSM_SRC_PDM  = 2'h1,
      ATSM_SRC_VBAT = 2'h2,
      ATSM_SRC_RSVD = 2'h3
   } atsm_src_t;

   // Framing formats
   typedef enum logic [1:0] {
      ATSM_FMT_TDM = 2'h0,
      ATSM_FMT_I2S = 2'h1,
      ATSM_FMT_LJ  = 2'h2
   } atsm_fmt_t;

   // Link state
   typedef enum logic [1:0] {
      ATSM_ST_IDLE = 2'b01,
      ATSM_ST_RUN  = 2'b10
   } atsm_state_t;

   // One frame worth of source samples
   typedef struct packed {
      logic [ATSM_WORD_W-1:0] ch1;
      logic [ATSM_WORD_W-1:0] ch2;
      logic [ATSM_WORD_W-1:0] ch3_pdm;
      logic [ATSM_WORD_W-1:0] vbat;
   } atsm_frame_t;

   // Register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } atsm_reg_req_t;
endpackage

// >>> dv/atsm_host_model.sv
// Host-side receiver model: makes the bit clock and frame sync, captures both data pins.
// Assumes clk is the bench clock; the bit clock runs only while a frame is requested.
`timescale 1ns/1ns
module atsm_host_model #(
   parameter int FRAME_BITS = 256
) (
   // Bench clock that paces the link
   input  wire logic clk,
   // Link clocks towards the device
   output logic      bclk,
   output logic      fsync,
   // Data pins from the device
   input  wire logic dout,
   input  wire logic dout_oe,
   input  wire logic secondary_data_out_pin,
   input  wire logic secondary_data_out_pin_oe
);
   import atsm_pkg::*;
   // Captured pin levels and enables, per pin and per bit of a frame
   logic cap_d  [2][FRAME_BITS];
   logic cap_oe [2][FRAME_BITS];

   // Idle link: bit clock parked high, sync low
   initial begin
      bclk  = 1'b1;
      fsync = 1'b0;
   end

   // Sync level for bit b; bit -1 is the level held before the frame
   function automatic logic sync_at(input atsm_fmt_t f, input int b);
      case (f)
         ATSM_FMT_TDM: return b == 0;
         ATSM_FMT_I2S: return (b < 0) || (b >= FRAME_BITS / 2);
         default:      return (b >= 0) && (b < FRAME_BITS / 2);
      endcase
   endfunction

   // One frame; sync moves at the rise, pins are sampled just before the next rise
   task automatic run_frame(input atsm_fmt_t f);
      fsync = sync_at(f, -1);
      repeat (8) @(negedge clk);
      // Lead-in bit at the pre-frame sync level, so the first sync change is seen
      bclk = 1'b0;
      repeat (4) @(negedge clk);
      bclk = 1'b1;
      for (int b = 0; b < FRAME_BITS; b++) begin
         fsync = sync_at(f, b);
         repeat (4) @(negedge clk);
         bclk = 1'b0;
         repeat (4) @(negedge clk);
         cap_d[0][b]  = dout;
         cap_oe[0][b] = dout_oe;
         cap_d[1][b]  = secondary_data_out_pin;
         cap_oe[1][b] = secondary_data_out_pin_oe;
         bclk = 1'b1;
      end
   endtask
endmodule // atsm_host_model

// >>> dv/tb.sv
// Self-checking bench for the transmit slot mapper: registers, buffer and slot mapping.
// Assumes the host model paces the link; slots are shortened to 8 bits.
`timescale 1ns/1ns
module tb;
   import atsm_pkg::*;
   localparam int SB = 8;
   localparam int FB = 32 * SB;
   localparam logic [7:0] ADDRS [4] = '{ATSM_OFF_PIN_SEL, ATSM_OFF_CH1, ATSM_OFF_CH2, ATSM_OFF_CH3};
   localparam logic [7:0] RSTS  [4] = '{ATSM_RST_PIN_SEL, ATSM_RST_CH1, ATSM_RST_CH2, ATSM_RST_CH3};
   localparam logic [7:0] MASKS [4] = '{8'h07, 8'h3f, 8'h3f, 8'h7f};
   localparam logic [7:0] CORNER [4][4] = '{'{8'h00, 8'h20, 8'h21, 8'h02},
      '{8'h02, 8'h2f, 8'h30, 8'h5f}, '{8'h04, 8'h00, 8'h1f, 8'h20}, '{8'h00, 8'h1f, 8'h1e, 8'h70}};
   // Design connections
   logic          clk;
   logic          rst;
   atsm_reg_req_t reg_req;
   logic [7:0]    reg_rdata;
   atsm_fmt_t     fmt;
   logic          in_valid;
   logic          in_ready;
   atsm_frame_t   in_frame;
   logic          bclk;
   logic          fsync;
   logic          dout;
   logic          dout_oe;
   logic          secondary_data_out_pin;
   logic          secondary_data_out_pin_oe;
   // Bench state
   int            miscompares;
   int            tests_run;
   int            seed;
   logic [7:0]    cfg [4];
   logic [7:0]    rd;
   atsm_frame_t   word;
   atsm_frame_t   pend [$];

   atsm_top #(.SLOT_BITS(SB), .BUF_DEPTH(2)) u_dut (.clk(clk), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .fmt(fmt), .in_valid(in_valid), .in_ready(in_ready),
      .in_frame(in_frame), .bclk(bclk), .fsync(fsync), .dout(dout), .dout_oe(dout_oe),
      .secondary_data_out_pin(secondary_data_out_pin), .secondary_data_out_pin_oe(secondary_data_out_pin_oe));

   atsm_host_model #(.FRAME_BITS(FB)) u_host (.clk(clk), .bclk(bclk), .fsync(fsync),
      .dout(dout), .dout_oe(dout_oe), .secondary_data_out_pin(secondary_data_out_pin), .secondary_data_out_pin_oe(secondary_data_out_pin_oe));

   // Bench clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Counts, verdict and end of run
   task automatic give_verdict();
      $display("Summary: %0d comparisons, %0d mismatches", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Single comparison point
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: %s saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One register cycle; read data is taken the cycle after the request
   task automatic reg_access(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
      @(negedge clk);
      reg_req = '{wr: wr, rd: !wr, addr: addr, wdata: wd};
      @(negedge clk);
      rd = reg_rdata;
      reg_req = '0;
   endtask

   // Offers one random frame word and holds it until the buffer takes it
   task automatic push_word();
      int n;
      n = 0;
      @(negedge clk);
      in_frame = {$random(seed), $random(seed), $random(seed), $random(seed)};
      in_valid = 1'b1;
      while (in_ready !== 1'b1) begin
         n++;
         if (n > 50) begin
            miscompares++;
            $display("Error at %0t: buffer never ready", $time);
            break;
         end
         @(negedge clk);
      end
      pend.push_back(in_frame);
      @(negedge clk);
      in_valid = 1'b0;
   endtask

   // Expected {enable, data} of one pin at one bit of the frame
   function automatic logic [1:0] exp_pin(input int pin, input int b);
      logic [1:0]  r;
      logic [7:0]  c;
      logic        on;
      logic [31:0] w;
      r = 2'b00;
      for (int ch = 0; ch < 3; ch++) begin
         c = cfg[ch + 1];
         on = (ch < 2) ? c[ATSM_EN_BIT] : (c[6:5] == 2'h1 || c[6:5] == 2'h2);
         w = (ch == 0) ? word.ch1 : (ch == 1) ? word.ch2 :
             (c[6:5] == 2'h2) ? word.vbat : word.ch3_pdm;
         if (on && cfg[0][ch] == pin[0] && c[4:0] == b / SB) begin
            r = r | {1'b1, w[31 - b % SB]};
         end
      end
      return r;
   endfunction

   // Runs one frame in format f and compares every bit of both pins
   task automatic frame_check(input atsm_fmt_t f);
      logic [1:0] e;
      @(negedge clk);
      fmt = f;
      word = (pend.size() > 0) ? pend.pop_front() : '0;
      u_host.run_frame(f);
      for (int b = 0; b < FB; b++) begin
         for (int p = 0; p < 2; p++) begin
            e = exp_pin(p, b);
            check(8'(u_host.cap_oe[p][b]), 8'(e[1]), "pin enable");
            if (e[1]) begin
               check(8'(u_host.cap_d[p][b]), 8'(e[0]), "pin data");
            end
         end
      end
      $display("Frame in format %0d done", f);
   endtask

   // Run time limit
   initial begin
      #6000000;
      miscompares++;
      $display("Error at %0t: run time limit", $time);
      give_verdict();
   end

   // Main sequence
   initial begin
      seed = 73102;
      miscompares = 0;
      tests_run = 0;
      rst = 1'b1;
      reg_req = '0;
      fmt = ATSM_FMT_TDM;
      in_valid = 1'b0;
      in_frame = '0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      // Reset values and an unmapped address
      for (int k = 0; k < 4; k++) begin
         reg_access(1'b0, ADDRS[k], 8'h00);
         check(rd, RSTS[k], "reset value");
         cfg[k] = RSTS[k];
      end
      reg_access(1'b0, 8'h21, 8'h00);
      check(rd, 8'h00, "unmapped read");
      $display("Register reset test done");
      // Default, corner and random mappings in every format
      for (int i = 0; i < 10; i++) begin
         for (int k = 0; k < 4 && i > 0; k++) begin
            cfg[k] = (i < 4) ? CORNER[i][k] : 8'($random(seed));
            cfg[k] = cfg[k] & MASKS[k];
            reg_access(1'b1, ADDRS[k], cfg[k]);
            reg_access(1'b0, ADDRS[k], 8'h00);
            check(rd, cfg[k], "readback");
         end
         push_word();
         frame_check(atsm_fmt_t'(i % 3));
      end
      // Far side stalls while two words fill the buffer, then two frames drain it and a third runs empty
      push_word();
      push_word();
      repeat (3) @(negedge clk);
      check(8'(in_ready), 8'h00, "ready while full");
      for (int k = 0; k < 3; k++) begin
         frame_check(ATSM_FMT_TDM);
      end
      $display("Buffer test done");
      give_verdict();
   end
endmodule // tb

// >>> hdl/atsm_buf.sv
// Small valid/ready buffer in front of the serialiser.
// Assumes both sides run on clk; no combinational path from out_ready to in_ready.
`timescale 1ns/1ns
module atsm_buf #(
   parameter int W     = 128,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL  = CW'(DEPTH);
   localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [CW-1:0] cnt, next_cnt;
   logic          push, pop;

   // Pointer and count update
   always_comb begin
      push     = in_valid && (cnt != FULL);
      pop      = out_ready && (cnt != '0);
      next_wp  = push ? ((wp == LASTP) ? '0 : wp + 1'b1) : wp;
      next_rp  = pop ? ((rp == LASTP) ? '0 : rp + 1'b1) : rp;
      next_cnt = cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end

   // Storage, written only on a push
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   assign in_ready  = (cnt != FULL);
   assign out_valid = (cnt != '0);
   assign out_data  = mem[rp];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   no_overflow_a: assert property (cnt == FULL && in_valid && !out_ready |=> cnt == FULL && $stable(wp))
      else $error("word pushed into full buffer");
   keep_word_a: assert property (cnt == FULL && !out_ready |=> cnt == FULL)
      else $error("word lost while stalled");
   fill_cv: cover property (cnt == FULL);
endmodule // atsm_buf

// >>> hdl/atsm_top.sv
// Transmit slot mapper for the first three output channels of the primary serial port.
// Assumes bclk and fsync come from another domain; register port and sample
// stream are on clk. Data changes on bclk falling edges, MSB first.
`timescale 1ns/1ns
module atsm_top
   import atsm_pkg::*;
#(
   parameter int SLOT_BITS = 32,
   parameter int BUF_DEPTH = 2
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Register port
   input  wire atsm_pkg::atsm_reg_req_t reg_req,
   output logic [7:0]                   reg_rdata,
   // Framing format select
   input  wire atsm_pkg::atsm_fmt_t     fmt,
   // Sample stream, one frame per word
   input  wire logic                    in_valid,
   output logic                         in_ready,
   input  wire atsm_pkg::atsm_frame_t   in_frame,
   // Link clocks from the far side
   input  wire logic                    bclk,
   input  wire logic                    fsync,
   // Primary data pin
   output logic                         dout,
   output logic                         dout_oe,
   // Secondary data pin
   output logic                         secondary_data_out_pin,
   output logic                         secondary_data_out_pin_oe
);
   import atsm_pkg::*;

   localparam int BW = (SLOT_BITS > 1) ? $clog2(SLOT_BITS) : 1;
   localparam logic [BW-1:0] BIT_LAST = BW'(SLOT_BITS - 1);

   // ---------------- Register file ----------------
   logic [7:0] cfg1, cfg2, cfg3, pin_sel;
   logic [7:0] next_cfg1, next_cfg2, next_cfg3, next_pin_sel, next_rdata;

   // Writes keep only the defined bits; reserved bits stay zero
   always_comb begin
      next_cfg1    = cfg1;
      next_cfg2    = cfg2;
      next_cfg3    = cfg3;
      next_pin_sel = pin_sel;
      next_rdata   = reg_rdata;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            ATSM_OFF_CH1:     next_cfg1    = reg_req.wdata & ATSM_MASK_CH12;
            ATSM_OFF_CH2:     next_cfg2    = reg_req.wdata & ATSM_MASK_CH12;
            ATSM_OFF_CH3:     next_cfg3    = reg_req.wdata & ATSM_MASK_CH3;
            ATSM_OFF_PIN_SEL: next_pin_sel = reg_req.wdata & ATSM_MASK_PIN_SEL;
            default:          next_cfg1    = cfg1;
         endcase
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            ATSM_OFF_CH1:     next_rdata = cfg1;
            ATSM_OFF_CH2:     next_rdata = cfg2;
            ATSM_OFF_CH3:     next_rdata = cfg3;
            ATSM_OFF_PIN_SEL: next_rdata = pin_sel;
            default:          next_rdata = 8'h00; // Unmapped offsets read zero
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg1      <= ATSM_RST_CH1;
         cfg2      <= ATSM_RST_CH2;
         cfg3      <= ATSM_RST_CH3;
         pin_sel   <= ATSM_RST_PIN_SEL;
         reg_rdata <= 8'h00;
      end else begin
         cfg1      <= next_cfg1;
         cfg2      <= next_cfg2;
         cfg3      <= next_cfg3;
         pin_sel   <= next_pin_sel;
         reg_rdata <= next_rdata;
      end
   end

   // ---------------- Link input synchronisers ----------------
   logic bclk_m, bclk_s, bclk_d, fsync_m, fsync_s;
   logic bclk_fall;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bclk_m  <= 1'b0;
         bclk_s  <= 1'b0;
         bclk_d  <= 1'b0;
         fsync_m <= 1'b0;
         fsync_s <= 1'b0;
      end else begin
         bclk_m  <= bclk;
         bclk_s  <= bclk_m;
         bclk_d  <= bclk_s;
         fsync_m <= fsync;
         fsync_s <= fsync_m;
      end
   end

   assign bclk_fall = bclk_d && !bclk_s;

   // ---------------- Sample buffer ----------------
   atsm_frame_t buf_data, cur, next_cur;
   logic        buf_valid, buf_pop, buf_ready, buf_take;

   // Only words that the source saw accepted may enter the buffer
   assign buf_take = in_valid && in_ready;

   atsm_buf #(
      .W     ($bits(atsm_frame_t)),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (buf_take),
      .in_ready  (buf_ready),
      .in_data   (in_frame),
      .out_valid (buf_valid),
      .out_ready (buf_pop),
      .out_data  (buf_data)
   );

   // ---------------- Frame and slot counters ----------------
   atsm_state_t state, next_state;
   logic [BW-1:0] bit_cnt, next_bit_cnt;
   logic [4:0]    slot_cnt, next_slot_cnt;
   logic          right, next_right, over, next_over;
   logic          fs_last, next_fs_last;
   logic          half_start, frame_start, is_tdm;
   logic [4:0]    slot_last, next_eff;

   // Frame edge detection and bit position tracking on each bclk fall
   always_comb begin
      is_tdm        = (fmt == ATSM_FMT_TDM);
      slot_last     = is_tdm ? ATSM_TDM_LAST : ATSM_HALF_LAST;
      half_start    = is_tdm ? (fsync_s && !fs_last) : (fsync_s != fs_last);
      next_state    = state;
      next_bit_cnt  = bit_cnt;
      next_slot_cnt = slot_cnt;
      next_right    = right;
      next_over     = over;
      next_fs_last  = fs_last;
      frame_start   = 1'b0;
      if (bclk_fall) begin
         next_fs_last = fsync_s;
         if (half_start) begin
            next_state    = ATSM_ST_RUN;
            next_bit_cnt  = '0;
            next_slot_cnt = '0;
            next_over     = 1'b0;
            // I2S left half is fsync low, left-justified left half is fsync high
            next_right    = is_tdm ? 1'b0 : ((fmt == ATSM_FMT_I2S) ? fsync_s : !fsync_s);
            frame_start   = !next_right;
         end else if (bit_cnt == BIT_LAST) begin
            next_bit_cnt = '0;
            if (slot_cnt == slot_last) begin
               next_over = 1'b1; // Past the last slot until the next frame edge
            end else begin
               next_slot_cnt = slot_cnt + 5'h01;
            end
         end else begin
            next_bit_cnt = bit_cnt + 1'b1;
         end
      end
      // Effective slot number as the slot fields count it
      next_eff = is_tdm ? next_slot_cnt : {next_right, next_slot_cnt[3:0]};
      // Take a fresh frame of samples at each frame start, zeros if none waits
      buf_pop  = frame_start && buf_valid;
      next_cur = cur;
      if (frame_start) begin
         next_cur = buf_valid ? buf_data : '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state    <= ATSM_ST_IDLE;
         bit_cnt  <= '0;
         slot_cnt <= '0;
         right    <= 1'b0;
         over     <= 1'b0;
         fs_last  <= 1'b0;
         cur      <= '0;
      end else begin
         state    <= next_state;
         bit_cnt  <= next_bit_cnt;
         slot_cnt <= next_slot_cnt;
         right    <= next_right;
         over     <= next_over;
         fs_last  <= next_fs_last;
         cur      <= next_cur;
      end
   end

   // ---------------- Channel claims ----------------
   logic [ATSM_CHANNELS-1:0] ch_en, ch_claim, ch_bit;
   logic [4:0]               ch_slot [ATSM_CHANNELS];
   logic [ATSM_WORD_W-1:0]   ch_word [ATSM_CHANNELS];
   atsm_src_t                src3;
   logic [ATSM_WORD_W-1:0]   shifted [ATSM_CHANNELS];

   // Per-channel enables and sources
   always_comb begin
      src3       = atsm_src_t'(cfg3[ATSM_SRC_MSB:ATSM_SRC_LSB]);
      ch_en[0]   = cfg1[ATSM_EN_BIT];
      ch_en[1]   = cfg2[ATSM_EN_BIT];
      ch_en[2]   = (src3 == ATSM_SRC_PDM) || (src3 == ATSM_SRC_VBAT);
      ch_slot[0] = cfg1[ATSM_SLOT_MSB:ATSM_SLOT_LSB];
      ch_slot[1] = cfg2[ATSM_SLOT_MSB:ATSM_SLOT_LSB];
      ch_slot[2] = cfg3[ATSM_SLOT_MSB:ATSM_SLOT_LSB];
      ch_word[0] = next_cur.ch1;
      ch_word[1] = next_cur.ch2;
      ch_word[2] = (src3 == ATSM_SRC_VBAT) ? next_cur.vbat : next_cur.ch3_pdm;
   end

   // A channel claims the bit when enabled and its slot is current
   for (genvar i = 0; i < ATSM_CHANNELS; i++) begin : g_ch
      assign ch_claim[i] = ch_en[i] && (next_state == ATSM_ST_RUN) && !next_over
                           && (next_eff == ch_slot[i]);
      assign shifted[i]  = ch_word[i] << next_bit_cnt;
      assign ch_bit[i]   = shifted[i][ATSM_WORD_W-1];
   end

   // ---------------- Pin drivers ----------------
   logic next_dout, next_dout_oe, next_secondary_data_out_pin, next_secondary_data_out_pin_oe;
   logic [ATSM_CHANNELS-1:0] to_pri, to_sec;

   // Route claims to the selected pin; unclaimed slots float
   always_comb begin
      to_pri        = ch_claim & ~pin_sel[ATSM_CHANNELS-1:0];
      to_sec        = ch_claim & pin_sel[ATSM_CHANNELS-1:0];
      next_dout     = dout;
      next_dout_oe  = dout_oe;
      next_secondary_data_out_pin    = secondary_data_out_pin;
      next_secondary_data_out_pin_oe = secondary_data_out_pin_oe;
      if (bclk_fall) begin
         next_dout_oe  = |to_pri;
         next_secondary_data_out_pin_oe = |to_sec;
         next_dout     = |(to_pri & ch_bit);
         next_secondary_data_out_pin    = |(to_sec & ch_bit);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout     <= 1'b0;
         dout_oe  <= 1'b0;
         secondary_data_out_pin    <= 1'b0;
         secondary_data_out_pin_oe <= 1'b0;
         in_ready <= 1'b0;
      end else begin
         dout     <= next_dout;
         dout_oe  <= next_dout_oe;
         secondary_data_out_pin    <= next_secondary_data_out_pin;
         secondary_data_out_pin_oe <= next_secondary_data_out_pin_oe;
         in_ready <= buf_ready && !(in_valid && in_ready); // Registered, conservative
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ch1_reset_a: assert property ($past(rst) |-> cfg1 == ATSM_RST_CH1)
      else $error("channel one reset value wrong");
   ch2_reset_a: assert property ($past(rst) |-> cfg2 == ATSM_RST_CH2)
      else $error("channel two reset value wrong");
   ch3_reset_a: assert property ($past(rst) |-> cfg3 == ATSM_RST_CH3)
      else $error("channel three reset value wrong");
   rsvd_read_a: assert property (reg_req.rd && reg_req.addr == ATSM_OFF_CH1
      |=> reg_rdata[7:6] == 2'b00) else $error("reserved bits not zero");
   all_off_a: assert property (bclk_fall && !ch_en[0] && !ch_en[1] && !ch_en[2]
      |=> !dout_oe && !secondary_data_out_pin_oe) else $error("pin driven with channels off");
   ch2_send_a: assert property (bclk_fall && ch_claim == 3'b010 && !pin_sel[1]
      |=> dout_oe && dout == $past(ch_bit[1])) else $error("channel two not sent");
   src_rsvd_a: assert property (bclk_fall && src3 == ATSM_SRC_RSVD
      && !ch_en[0] && !ch_en[1] |=> !dout_oe && !secondary_data_out_pin_oe)
      else $error("reserved source drives pin");
   left_slot_a: assert property (bclk_fall && !is_tdm && !next_right && !next_over
      && next_state == ATSM_ST_RUN && ch_en[0] && !pin_sel[0]
      && cfg1[4:0] == {1'b0, next_slot_cnt[3:0]} |=> dout_oe)
      else $error("left half slot missed");
   right_slot_a: assert property (bclk_fall && !is_tdm && next_right && !next_over
      && next_state == ATSM_ST_RUN && ch_en[0] && !pin_sel[0]
      && cfg1[4:0] == {1'b1, next_slot_cnt[3:0]} |=> dout_oe)
      else $error("right half slot missed");
   pin_route_a: assert property (bclk_fall && ch_claim == 3'b001 && pin_sel[0]
      |=> secondary_data_out_pin_oe && !dout_oe) else $error("pin select ignored");
   idle_float_a: assert property (bclk_fall && ch_claim == 3'b000
      |=> (!dout_oe && !secondary_data_out_pin_oe) [*2]) else $error("unclaimed slot driven");

   pri_cv: cover property (bclk_fall && to_pri[0] ##1 dout_oe);
   sec_cv: cover property (bclk_fall && to_sec[2] ##1 secondary_data_out_pin_oe);
   i2s_cv: cover property (frame_start && fmt == ATSM_FMT_I2S);
   stall_cv: cover property (in_valid && !in_ready);
endmodule // atsm_top
